// [hdl/ssc_params.svh]
// What this block does
// - 24-bit words, msb first, into shift register
// - latch enable rise copies word to latch
// - low four bits address; bit0 zero selects n counter (latch 0)
// - bit0 one: bits 3..1 pick latch 0-7
// - host sends n counter word last
// - only n counter write clears lock detect and reloads fastlock counter from timeout field
// - host skips extended latch unless extended mode
// - order field: 0 fourth, 2 second, 3 third
// - dither field: 0 off, 1 weak, 2 strong
// - slip reduction factors: half, quarter, sixteenth
// - host caps charge pump per slip factor
// - host sets denom_warn on every extended-mode start, no 4095 check
`ifndef SSC_PARAMS_SVH
`define SSC_PARAMS_SVH

// ----------------------------------------------------------------
// serial word layout
// ----------------------------------------------------------------
`define SSC_WORD_W        24
`define SSC_ADDR_W        4
`define SSC_NUM_LATCH     8
`define SSC_BITCNT_W      5
`define SSC_N_COUNTER_IDX 3'h0
`define SSC_EXT_FRAC_IDX  3'h7
`define SSC_FIRST_IDX     3'h1
// ----------------------------------------------------------------
// field positions inside latched words
// ----------------------------------------------------------------
`define SSC_ORDER_IDX     3'h5
`define SSC_ORDER_LSB     4
`define SSC_DITHER_IDX    3'h5
`define SSC_DITHER_LSB    6
`define SSC_SLIP_IDX      3'h6
`define SSC_SLIP_LSB      4
`define SSC_TIMEOUT_IDX   3'h6
`define SSC_TIMEOUT_LSB   6
`define SSC_TIMEOUT_W     14
// ----------------------------------------------------------------
// host register map
// ----------------------------------------------------------------
`define SSC_REG_CTRL      8'h00
`define SSC_REG_STATUS    8'h04
`define SSC_REG_CAP       8'h08
`define SSC_REG_STAGE     8'h20
`define SSC_CTRL_START    0
`define SSC_CTRL_EXT      1
`define SSC_CP_MAX_HALF   4'h8
`define SSC_CP_MAX_QUART  4'h4
`define SSC_CP_MAX_SIXT   4'h1
`define SSC_DENOM_MAX     12'hFFF
`define SSC_RESP_OKAY     2'h0
`define SSC_RESP_SLVERR   2'h2

`endif

// [hdl/ssc_pkg.sv]
package ssc_pkg;

	typedef enum logic [2:0]
	{
		SSC_ORDER_FOURTH = 3'h4,
		SSC_ORDER_SECOND = 3'h2,
		SSC_ORDER_THIRD  = 3'h3
	} ssc_order_e;

	typedef enum logic [1:0]
	{
		SSC_DITHER_OFF    = 2'h0,
		SSC_DITHER_WEAK   = 2'h1,
		SSC_DITHER_STRONG = 2'h2
	} ssc_dither_e;

	typedef enum logic [1:0]
	{
		SSC_SLIP_OFF       = 2'h0,
		SSC_SLIP_HALF      = 2'h1,
		SSC_SLIP_QUARTER   = 2'h2,
		SSC_SLIP_SIXTEENTH = 2'h3
	} ssc_slip_e;

	typedef enum logic [2:0]
	{
		SSC_DEV_IDLE  = 3'b001,
		SSC_DEV_SHIFT = 3'b010,
		SSC_DEV_LATCH = 3'b100
	} ssc_dev_state_e;

	typedef enum logic [3:0]
	{
		SSC_HOST_IDLE   = 4'b0001,
		SSC_HOST_LOAD   = 4'b0010,
		SSC_HOST_SHIFT  = 4'b0100,
		SSC_HOST_STROBE = 4'b1000
	} ssc_host_state_e;

endpackage

// [hdl/ssc_if.sv]
interface ssc_if;

	logic serial_clk;
	logic serial_data;
	logic latch_strobe_pin;

	modport host
	(
		output serial_clk,
		output serial_data,
		output latch_strobe_pin
	);

	modport dev
	(
		input  serial_clk,
		input  serial_data,
		input  latch_strobe_pin
	);

endinterface

// [hdl/ssc_dev.sv]
`include "ssc_params.svh"

module ssc_dev
	import ssc_pkg::*;
#(
	parameter int TIMEOUT_W = `SSC_TIMEOUT_W
)
(
	ssc_if.dev                       link,
	input  wire logic                nrst,
	output logic [`SSC_NUM_LATCH-1:0][`SSC_WORD_W-1:0] latch_words,
	output logic                     latch_pulse,
	output logic [2:0]               latch_index,
	output logic                     word_length_err,
	output ssc_order_e               modulator_order_sel,
	output logic                     order_invalid,
	output ssc_dither_e              dither_level_sel,
	output logic                     dither_invalid,
	output ssc_slip_e                slip_reduction_factor,
	output logic                     lock_detect_clear,
	output logic                     fastlock_active
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [2:0] latch_sel(
		input logic [`SSC_ADDR_W-1:0] word_address_field
	);
		if (!word_address_field[0])
			latch_sel = `SSC_N_COUNTER_IDX;
		else
			latch_sel = word_address_field[3:1];
	endfunction

	function automatic logic [1:0] field2(
		input logic [`SSC_WORD_W-1:0] word,
		input int                     lsb
	);
		field2 = word[lsb +: 2];
	endfunction

	// ----------------------------------------------------------------
	// pin synchronisers, serial clock domain
	// ----------------------------------------------------------------
	logic [1:0] data_sync;
	logic [1:0] strobe_sync;
	logic       strobe_prev;

	always_ff @(posedge link.serial_clk)
	begin
		if (!nrst)
		begin
			data_sync   <= 2'h0;
			strobe_sync <= 2'h3;
			strobe_prev <= 1'b1;
		end
		else
		begin
			data_sync   <= {data_sync[0], link.serial_data};
			strobe_sync <= {strobe_sync[0], link.latch_strobe_pin};
			strobe_prev <= strobe_sync[1];
		end
	end

	wire logic strobe_low  = !strobe_sync[1];
	wire logic strobe_rise = strobe_sync[1] && !strobe_prev;

	// ----------------------------------------------------------------
	// shift register and word framing
	// ----------------------------------------------------------------
	ssc_dev_state_e                state;
	ssc_dev_state_e                next_state;
	logic [`SSC_WORD_W-1:0]        shift_reg;
	logic [`SSC_WORD_W-1:0]        next_shift_reg;
	logic [`SSC_BITCNT_W-1:0]      bit_cnt;
	logic [`SSC_BITCNT_W-1:0]      next_bit_cnt;

	always_comb
	begin
		next_state     = state;
		next_shift_reg = shift_reg;
		next_bit_cnt   = bit_cnt;
		case (state)
			SSC_DEV_IDLE:
			begin
				if (strobe_low)
				begin
					next_shift_reg = {shift_reg[`SSC_WORD_W-2:0],
						data_sync[1]};
					next_bit_cnt   = `SSC_BITCNT_W'(1);
					next_state     = SSC_DEV_SHIFT;
				end
			end
			SSC_DEV_SHIFT:
			begin
				if (strobe_low)
				begin
					next_shift_reg = {shift_reg[`SSC_WORD_W-2:0],
						data_sync[1]};
					if (bit_cnt != 5'h1F)
						next_bit_cnt = bit_cnt + 5'h01;
				end
				else if (strobe_rise)
					next_state = SSC_DEV_LATCH;
			end
			SSC_DEV_LATCH:
			begin
				next_bit_cnt = 5'h00;
				next_state   = SSC_DEV_IDLE;
			end
			default:
				next_state = SSC_DEV_IDLE;
		endcase
	end

	always_ff @(posedge link.serial_clk)
	begin
		if (!nrst)
		begin
			state     <= SSC_DEV_IDLE;
			shift_reg <= 24'h000000;
			bit_cnt   <= 5'h00;
		end
		else
		begin
			state     <= next_state;
			shift_reg <= next_shift_reg;
			bit_cnt   <= next_bit_cnt;
		end
	end

	// ----------------------------------------------------------------
	// control latches
	// ----------------------------------------------------------------
	logic [`SSC_NUM_LATCH-1:0][`SSC_WORD_W-1:0] next_latch_words;
	logic                     next_latch_pulse;
	logic [2:0]               next_latch_index;
	logic                     next_word_length_err;
	logic [2:0]               sel;

	always_comb
	begin
		sel                  = latch_sel(shift_reg[`SSC_ADDR_W-1:0]);
		next_latch_words     = latch_words;
		next_latch_pulse     = 1'b0;
		next_latch_index     = latch_index;
		next_word_length_err = word_length_err;
		if (state == SSC_DEV_LATCH)
		begin
			next_latch_words[sel] = shift_reg;
			next_latch_pulse      = 1'b1;
			next_latch_index      = sel;
			next_word_length_err  =
				(bit_cnt != `SSC_BITCNT_W'(`SSC_WORD_W));
		end
	end

	always_ff @(posedge link.serial_clk)
	begin
		if (!nrst)
		begin
			latch_words     <= '0;
			latch_pulse     <= 1'b0;
			latch_index     <= 3'h0;
			word_length_err <= 1'b0;
		end
		else
		begin
			latch_words     <= next_latch_words;
			latch_pulse     <= next_latch_pulse;
			latch_index     <= next_latch_index;
			word_length_err <= next_word_length_err;
		end
	end

	// ----------------------------------------------------------------
	// mode fields
	// ----------------------------------------------------------------
	ssc_order_e  next_order;
	logic        next_order_invalid;
	ssc_dither_e next_dither;
	logic        next_dither_invalid;
	ssc_slip_e   next_slip;
	logic [1:0]  order_raw;
	logic [1:0]  dither_raw;

	always_comb
	begin
		order_raw  = field2(latch_words[`SSC_ORDER_IDX], `SSC_ORDER_LSB);
		dither_raw = field2(latch_words[`SSC_DITHER_IDX],
			`SSC_DITHER_LSB);
		next_order_invalid  = 1'b0;
		next_dither_invalid = 1'b0;
		case (order_raw)
			2'h0:    next_order = SSC_ORDER_FOURTH;
			2'h2:    next_order = SSC_ORDER_SECOND;
			2'h3:    next_order = SSC_ORDER_THIRD;
			default:
			begin
				next_order         = SSC_ORDER_THIRD;
				next_order_invalid = 1'b1;
			end
		endcase
		case (dither_raw)
			2'h0:    next_dither = SSC_DITHER_OFF;
			2'h1:    next_dither = SSC_DITHER_WEAK;
			2'h2:    next_dither = SSC_DITHER_STRONG;
			default:
			begin
				next_dither         = SSC_DITHER_STRONG;
				next_dither_invalid = 1'b1;
			end
		endcase
		next_slip = ssc_slip_e'(field2(latch_words[`SSC_SLIP_IDX],
			`SSC_SLIP_LSB));
	end

	always_ff @(posedge link.serial_clk)
	begin
		if (!nrst)
		begin
			modulator_order_sel   <= SSC_ORDER_FOURTH;
			order_invalid         <= 1'b0;
			dither_level_sel      <= SSC_DITHER_OFF;
			dither_invalid        <= 1'b0;
			slip_reduction_factor <= SSC_SLIP_OFF;
		end
		else
		begin
			modulator_order_sel   <= next_order;
			order_invalid         <= next_order_invalid;
			dither_level_sel      <= next_dither;
			dither_invalid        <= next_dither_invalid;
			slip_reduction_factor <= next_slip;
		end
	end

	// ----------------------------------------------------------------
	// lock detect and fastlock counter restart
	// ----------------------------------------------------------------
	logic [TIMEOUT_W-1:0] fast_cnt;
	logic [TIMEOUT_W-1:0] next_fast_cnt;
	logic                 next_lock_clear;
	logic                 next_fast_active;
	logic                 n_write;

	always_comb
	begin
		n_write = (state == SSC_DEV_LATCH) &&
			(sel == `SSC_N_COUNTER_IDX);
		next_lock_clear  = n_write;
		next_fast_cnt    = fast_cnt;
		if (n_write)
			next_fast_cnt = latch_words[`SSC_TIMEOUT_IDX]
				[`SSC_TIMEOUT_LSB +: TIMEOUT_W];
		else if (fast_cnt != '0)
			next_fast_cnt = fast_cnt - TIMEOUT_W'(1);
		next_fast_active = (next_fast_cnt != '0);
	end

	always_ff @(posedge link.serial_clk)
	begin
		if (!nrst)
		begin
			fast_cnt          <= '0;
			lock_detect_clear <= 1'b0;
			fastlock_active   <= 1'b0;
		end
		else
		begin
			fast_cnt          <= next_fast_cnt;
			lock_detect_clear <= next_lock_clear;
			fastlock_active   <= next_fast_active;
		end
	end

endmodule

// [hdl/ssc_host.sv]
`include "ssc_params.svh"

module ssc_host
	import ssc_pkg::*;
#(
	parameter int HALF_DIV = 1
)
(
	input  wire logic        sys_clk,
	input  wire logic        nrst,
	ssc_if.host              link,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);

	// ----------------------------------------------------------------
	// registers and bus slave
	// ----------------------------------------------------------------
	logic [7:0][23:0] stage;
	logic             ext_mode;
	logic [5:0]       cap;
	logic             cap_err;
	logic             denom_warn;
	logic             busy;
	logic             start_req;
	logic             aw_go;
	logic             ar_go;
	logic             w_hit;
	logic             r_hit;
	logic [31:0]      rd_val;

	function automatic logic stage_hit(input logic [7:0] a);
		stage_hit = (a[7:5] == 3'(`SSC_REG_STAGE >> 5)) && (a[1:0] == 2'h0);
	endfunction

	function automatic logic [3:0] cp_limit(input logic [1:0] f);
		case (f)
			2'h1:    cp_limit = `SSC_CP_MAX_HALF;
			2'h2:    cp_limit = `SSC_CP_MAX_QUART;
			2'h3:    cp_limit = `SSC_CP_MAX_SIXT;
			default: cp_limit = 4'hF;
		endcase
	endfunction

	always_comb
	begin
		aw_go = s_axi_awvalid && s_axi_wvalid && !s_axi_awready &&
			!s_axi_bvalid;
		ar_go = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
		w_hit = stage_hit(s_axi_awaddr) ||
			s_axi_awaddr == `SSC_REG_CTRL || s_axi_awaddr == `SSC_REG_CAP;
		r_hit = stage_hit(s_axi_araddr) || s_axi_araddr == `SSC_REG_CTRL
			|| s_axi_araddr == `SSC_REG_CAP ||
			s_axi_araddr == `SSC_REG_STATUS;
		rd_val = 32'h00000000;
		if (stage_hit(s_axi_araddr))
			rd_val = {8'h00, stage[s_axi_araddr[4:2]]};
		else if (s_axi_araddr == `SSC_REG_CTRL)
			rd_val = {30'h00000000, ext_mode, 1'b0};
		else if (s_axi_araddr == `SSC_REG_CAP)
			rd_val = {26'h0000000, cap};
		else if (s_axi_araddr == `SSC_REG_STATUS)
			rd_val = {29'h00000000, denom_warn, cap_err, busy};
	end

	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `SSC_RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rresp   <= `SSC_RESP_OKAY;
			s_axi_rdata   <= 32'h00000000;
			stage         <= '0;
			ext_mode      <= 1'b0;
			cap           <= 6'h00;
			start_req     <= 1'b0;
		end
		else
		begin
			s_axi_awready <= aw_go;
			s_axi_wready  <= aw_go;
			start_req     <= 1'b0;
			if (aw_go)
			begin
				s_axi_bresp  <= w_hit ? `SSC_RESP_OKAY : `SSC_RESP_SLVERR;
				if (stage_hit(s_axi_awaddr) && s_axi_wstrb[0])
					stage[s_axi_awaddr[4:2]] <= s_axi_wdata[23:0];
				if (s_axi_awaddr == `SSC_REG_CTRL && s_axi_wstrb[0])
				begin
					ext_mode  <= s_axi_wdata[`SSC_CTRL_EXT];
					start_req <= s_axi_wdata[`SSC_CTRL_START];
				end
				if (s_axi_awaddr == `SSC_REG_CAP && s_axi_wstrb[0])
					cap <= s_axi_wdata[5:0];
			end
			// response only after the address/data handshake edge
			if (s_axi_awready)
				s_axi_bvalid <= 1'b1;
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			s_axi_arready <= ar_go;
			if (ar_go)
			begin
				s_axi_rdata  <= rd_val;
				s_axi_rresp  <= r_hit ? `SSC_RESP_OKAY : `SSC_RESP_SLVERR;
			end
			if (s_axi_arready)
				s_axi_rvalid <= 1'b1;
			else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// serial clock divider and word sequencer
	// ----------------------------------------------------------------
	ssc_host_state_e state;
	ssc_host_state_e next_state;
	logic [7:0]      div_cnt;
	logic            sclk;
	logic            fall;
	logic [2:0]      idx;
	logic [2:0]      next_idx;
	logic [23:0]     word;
	logic [23:0]     next_word;
	logic [4:0]      cnt;
	logic [4:0]      next_cnt;
	logic            sdata;
	logic            next_sdata;
	logic            strobe;
	logic            next_strobe;
	logic            next_cap_err;
	logic            next_denom_warn;

	assign fall  = sclk && (div_cnt == 8'(HALF_DIV - 1));
	assign busy  = (state != SSC_HOST_IDLE);
	assign link.serial_clk       = sclk;
	assign link.serial_data      = sdata;
	assign link.latch_strobe_pin = strobe;

	always_comb
	begin
		next_state      = state;
		next_idx        = idx;
		next_word       = word;
		next_cnt        = cnt;
		next_sdata      = sdata;
		next_strobe     = strobe;
		next_cap_err    = cap_err;
		next_denom_warn = denom_warn;
		case (state)
			SSC_HOST_IDLE:
			begin
				if (start_req)
				begin
					next_cap_err    = cap[3:0] > cp_limit(cap[5:4]);
					next_denom_warn = ext_mode;
					next_idx        = `SSC_FIRST_IDX;
					if (!next_cap_err)
						next_state = SSC_HOST_LOAD;
				end
			end
			SSC_HOST_LOAD:
			begin
				next_word = (idx == `SSC_N_COUNTER_IDX) ?
					{stage[idx][23:1], 1'b0} :
					{stage[idx][23:4], idx, 1'b1};
				if (fall)
				begin
					next_strobe = 1'b0;
					next_sdata  = next_word[23];
					next_cnt    = 5'h17;
					next_state  = SSC_HOST_SHIFT;
				end
			end
			SSC_HOST_SHIFT:
			begin
				if (fall)
				begin
					if (cnt == 5'h00)
					begin
						next_strobe = 1'b1;
						next_state  = SSC_HOST_STROBE;
					end
					else
					begin
						next_cnt   = cnt - 5'h01;
						next_sdata = word[cnt - 5'h01];
					end
				end
			end
			SSC_HOST_STROBE:
			begin
				if (fall)
				begin
					if (idx == `SSC_N_COUNTER_IDX)
						next_state = SSC_HOST_IDLE;
					else
					begin
						next_state = SSC_HOST_LOAD;
						if (idx == 3'h6 && !ext_mode)
							next_idx = `SSC_N_COUNTER_IDX;
						else if (idx == `SSC_EXT_FRAC_IDX)
							next_idx = `SSC_N_COUNTER_IDX;
						else
							next_idx = idx + 3'h1;
					end
				end
			end
			default:
				next_state = SSC_HOST_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			state      <= SSC_HOST_IDLE;
			div_cnt    <= 8'h00;
			sclk       <= 1'b0;
			idx        <= 3'h0;
			word       <= 24'h000000;
			cnt        <= 5'h00;
			sdata      <= 1'b0;
			strobe     <= 1'b1;
			cap_err    <= 1'b0;
			denom_warn <= 1'b0;
		end
		else
		begin
			if (div_cnt == 8'(HALF_DIV - 1))
			begin
				div_cnt <= 8'h00;
				sclk    <= !sclk;
			end
			else
				div_cnt <= div_cnt + 8'h01;
			state      <= next_state;
			idx        <= next_idx;
			word       <= next_word;
			cnt        <= next_cnt;
			sdata      <= next_sdata;
			strobe     <= next_strobe;
			cap_err    <= next_cap_err;
			denom_warn <= next_denom_warn;
		end
	end

endmodule

// [test/ssc_chk.sv]
`include "ssc_params.svh"

module ssc_chk
	import ssc_pkg::*;
(
	input  wire logic         serial_clk,
	input  wire logic         serial_data,
	input  wire logic         latch_strobe_pin,
	input  wire logic         nrst,
	input  wire logic [`SSC_NUM_LATCH-1:0][`SSC_WORD_W-1:0] latch_words,
	input  wire logic         latch_pulse,
	input  wire logic [2:0]   latch_index,
	input  wire logic         word_length_err,
	input  wire ssc_order_e   modulator_order_sel,
	input  wire ssc_dither_e  dither_level_sel,
	input  wire ssc_slip_e    slip_reduction_factor,
	input  wire logic         lock_detect_clear
);
	// ----------------------------------------------------------------
	// shadow of the serial word
	// ----------------------------------------------------------------
	logic [4:0]  bit_cnt, next_bit_cnt;
	logic [23:0] shadow, next_shadow, word_q, next_word_q;
	logic [2:0]  exp_idx;
	ssc_order_e  ord_exp;
	ssc_dither_e dither_level_sel_exp;

	always_comb
	begin
		next_bit_cnt = latch_strobe_pin ? 5'h00 : bit_cnt + 5'h01;
		next_shadow = latch_strobe_pin ? shadow : {shadow[22:0], serial_data};
		next_word_q = (latch_strobe_pin && bit_cnt != 5'h00) ? shadow : word_q;
		exp_idx = word_q[0] ? word_q[3:1] : 3'h0;
		case (latch_words[`SSC_ORDER_IDX][`SSC_ORDER_LSB+:2])
			2'h0: ord_exp = SSC_ORDER_FOURTH;
			2'h2: ord_exp = SSC_ORDER_SECOND;
			default: ord_exp = SSC_ORDER_THIRD;
		endcase
		dither_level_sel_exp = ssc_dither_e'(latch_words[`SSC_DITHER_IDX][7:6]);
		if (latch_words[`SSC_DITHER_IDX][7:6] == 2'h3)
			dither_level_sel_exp = SSC_DITHER_STRONG;
	end

	always_ff @(posedge serial_clk)
	begin
		bit_cnt <= nrst ? next_bit_cnt : 5'h00;
		shadow <= nrst ? next_shadow : 24'h000000;
		word_q <= nrst ? next_word_q : 24'h000000;
	end

	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	default clocking @(posedge serial_clk); endclocking
	default disable iff (!nrst);

	property p_frame_len;
		$rose(latch_strobe_pin) |-> bit_cnt == 5'h18;
	endproperty
	a_frame_len: assert property (p_frame_len) else $error("frame length");
	property p_latch_rise;
		$rose(latch_strobe_pin) |-> ##[1:6] latch_pulse;
	endproperty
	a_latch_rise: assert property (p_latch_rise) else $error("no latch");
	property p_pulse_one;
		latch_pulse |=> !latch_pulse;
	endproperty
	a_pulse_one: assert property (p_pulse_one) else $error("long pulse");
	property p_index;
		latch_pulse |-> latch_index == exp_idx;
	endproperty
	a_index: assert property (p_index) else $error("bad index");
	property p_content;
		latch_pulse |-> ##[0:1] (latch_words[exp_idx] == word_q);
	endproperty
	a_content: assert property (p_content) else $error("bad word");
	property p_n_only;
		latch_pulse && exp_idx == 3'h0 |->
			latch_words[7:1] == $past(latch_words[7:1]);
	endproperty
	a_n_only: assert property (p_n_only) else $error("other latch hit");
	property p_clear;
		lock_detect_clear |-> latch_pulse && latch_index == 3'h0;
	endproperty
	a_clear: assert property (p_clear) else $error("stray clear");
	property p_clear_n;
		latch_pulse && latch_index == 3'h0 |-> lock_detect_clear;
	endproperty
	a_clear_n: assert property (p_clear_n) else $error("no clear");
	property p_order;
		modulator_order_sel == $past(ord_exp);
	endproperty
	a_order: assert property (p_order) else $error("order");
	property p_dither;
		dither_level_sel == $past(dither_level_sel_exp);
	endproperty
	a_dither: assert property (p_dither) else $error("dither");
	property p_slip;
		slip_reduction_factor ==
			ssc_slip_e'($past(latch_words[`SSC_SLIP_IDX][5:4]));
	endproperty
	a_slip: assert property (p_slip) else $error("slip");
	property p_len_ok;
		!word_length_err;
	endproperty
	a_len_ok: assert property (p_len_ok) else $error("length flag");
endmodule

// [test/tb_synth_serial_config_port.sv]
`include "ssc_params.svh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin bad_count++; \
 $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end

module tb_synth_serial_config_port
	import ssc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic        sys_clk, host_nrst, dev_nrst;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready;
	logic [`SSC_NUM_LATCH-1:0][`SSC_WORD_W-1:0] latch_words;
	logic        latch_pulse, word_length_err, order_invalid, dither_invalid;
	logic        lock_detect_clear, fastlock_active;
	logic [2:0]  latch_index;
	ssc_order_e  modulator_order_sel;
	ssc_dither_e dither_level_sel;
	ssc_slip_e   slip_reduction_factor;
	int          bad_count, checks, cyc;
	logic [2:0]  idx_q[$];
	logic [23:0] stage[8];
	logic [31:0] rd;

	ssc_if link_if();
	ssc_host #(.HALF_DIV(1)) u_ssc_host(.sys_clk(sys_clk), .nrst(host_nrst),
		.link(link_if), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
	ssc_dev u_ssc_dev(.link(link_if), .nrst(dev_nrst),
		.latch_words(latch_words), .latch_pulse(latch_pulse),
		.latch_index(latch_index), .word_length_err(word_length_err),
		.modulator_order_sel(modulator_order_sel),
		.order_invalid(order_invalid), .dither_level_sel(dither_level_sel),
		.dither_invalid(dither_invalid),
		.slip_reduction_factor(slip_reduction_factor),
		.lock_detect_clear(lock_detect_clear),
		.fastlock_active(fastlock_active));
	ssc_chk u_ssc_chk(.serial_clk(link_if.serial_clk),
		.serial_data(link_if.serial_data),
		.latch_strobe_pin(link_if.latch_strobe_pin), .nrst(dev_nrst),
		.latch_words(latch_words), .latch_pulse(latch_pulse),
		.latch_index(latch_index), .word_length_err(word_length_err),
		.modulator_order_sel(modulator_order_sel),
		.dither_level_sel(dither_level_sel),
		.slip_reduction_factor(slip_reduction_factor),
		.lock_detect_clear(lock_detect_clear));

	// ----------------------------------------------------------------
	// clock, timeout, latch monitor
	// ----------------------------------------------------------------
	initial
	begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 30000)
		begin
			bad_count++;
			end_sim();
		end
	end

	always @(posedge link_if.serial_clk)
		if (latch_pulse === 1'b1)
			idx_q.push_back(latch_index);

	// ----------------------------------------------------------------
	// bus tasks
	// ----------------------------------------------------------------
	task automatic end_sim;
		if (bad_count == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge sys_clk);
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
		end
		while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		`CHK("bresp", er, s_axi_bresp)
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
		input logic [1:0] er);
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge sys_clk);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end
		while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		d = s_axi_rdata;
		`CHK("rresp", er, s_axi_rresp)
	endtask

	task automatic run_seq(input logic [1:0] ord, input logic [1:0] dth,
		input logic [1:0] slp, input logic [3:0] gain, input logic ext);
		ssc_order_e eo;
		int         cnt;
		for (int k = 0; k < 8; k++)
		begin
			stage[k] = {12'h5A0 + 12'(k), 8'h00, 4'hE};
			if (k == 5) stage[k][7:4] = {dth, ord};
			if (k == 6) stage[k][19:4] = {14'h0010, slp};
			axi_wr(`SSC_REG_STAGE + 8'(4 * k), {8'h00, stage[k]}, `SSC_RESP_OKAY);
		end
		axi_wr(`SSC_REG_CAP, {26'h0, slp, gain}, `SSC_RESP_OKAY);
		idx_q.delete();
		axi_wr(`SSC_REG_CTRL, {30'h0, ext, 1'b1}, `SSC_RESP_OKAY);
		cnt = ext ? 8 : 7;
		while (idx_q.size() != cnt)
			@(posedge sys_clk);
		repeat (6) @(posedge sys_clk);
		for (int i = 0; i < cnt; i++)
			`CHK("index", (i == cnt - 1) ? 3'h0 : 3'(i + 1), idx_q[i])
		`CHK("w0", {stage[0][23:4], 1'b0},
			{latch_words[0][23:4], latch_words[0][0]})
		for (int k = 1; k < cnt; k++)
			`CHK("word", {stage[k][23:4], 3'(k), 1'b1}, latch_words[k])
		eo = ord == 2'h0 ? SSC_ORDER_FOURTH :
			ord == 2'h2 ? SSC_ORDER_SECOND : SSC_ORDER_THIRD;
		`CHK("order", eo, modulator_order_sel)
		`CHK("ord_bad", ord == 2'h1, order_invalid)
		`CHK("dither", ssc_dither_e'(dth), dither_level_sel)
		`CHK("dither_level_sel_bad", dth == 2'h3, dither_invalid)
		`CHK("slip", ssc_slip_e'(slp), slip_reduction_factor)
		`CHK("fastlock", 1'b1, fastlock_active)
		axi_rd(`SSC_REG_STATUS, rd, `SSC_RESP_OKAY);
		`CHK("status", {ext, 2'h0}, rd[2:0])
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		{host_nrst, dev_nrst, s_axi_awvalid, s_axi_wvalid} = 4'h0;
		{s_axi_bready, s_axi_arvalid, s_axi_rready} = 3'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		{bad_count, checks, cyc} = 0;
		repeat (12) @(posedge sys_clk);
		host_nrst <= 1'b1;
		repeat (12) @(posedge sys_clk);
		dev_nrst <= 1'b1;
		repeat (4) @(posedge sys_clk);
		`CHK("rst_words", {(`SSC_NUM_LATCH * `SSC_WORD_W){1'b0}}, latch_words)
		axi_wr(8'h14, 32'h0, `SSC_RESP_SLVERR);
		axi_rd(8'h40, rd, `SSC_RESP_SLVERR);
		`CHK("unmapped", 32'h0, rd)
		run_seq(2'h0, 2'h0, 2'h1, `SSC_CP_MAX_HALF, 1'b0);
		`CHK("w7_idle", 24'h000000, latch_words[7])
		run_seq(2'h2, 2'h1, 2'h2, `SSC_CP_MAX_QUART, 1'b0);
		run_seq(2'h3, 2'h2, 2'h3, `SSC_CP_MAX_SIXT, 1'b1);
		axi_wr(`SSC_REG_CAP, {26'h0, 2'h1, 4'h9}, `SSC_RESP_OKAY);
		idx_q.delete();
		axi_wr(`SSC_REG_CTRL, 32'h1, `SSC_RESP_OKAY);
		repeat (200) @(posedge sys_clk);
		axi_rd(`SSC_REG_STATUS, rd, `SSC_RESP_OKAY);
		`CHK("cap_err", 1'b1, rd[1])
		`CHK("refused", 0, idx_q.size())
		end_sim();
	end
endmodule
